// ===== design/cmo_message_objects.sv
// message object store, control elements and transmit selection
`timescale 1ns/1ps
`default_nettype none

module cmo_message_objects (
	input  wire logic                               clk,        // 25 MHz cpu clock
	input  wire logic                               reset,      // asynchronous, active high
	input  wire logic [cmo_pkg::ADDR_W-1:0]         addr,       // byte address, bit 0 ignored
	input  wire logic [cmo_pkg::DATA_W-1:0]         wr_data,    // write word
	input  wire logic                               wr_en,      // one-cycle write strobe
	input  wire logic                               rd_en,      // one-cycle read strobe
	output logic      [cmo_pkg::DATA_W-1:0]         rd_data,    // read word, cycle after rd_en only
	input  wire logic                               rx_store,   // engine stores an accepted data frame
	input  wire logic                               rx_remote,  // engine received a remote request
	input  wire logic [cmo_pkg::IDX_W-1:0]          rx_index,   // object addressed by rx_store/rx_remote
	input  wire logic [cmo_pkg::RX_DATA_W-1:0]      rx_data,    // payload, byte 0 in bits 7:0
	input  wire logic [cmo_pkg::DLC_W-1:0]          rx_dlc,     // received length code
	input  wire logic                               tx_start,   // engine takes the offered object
	input  wire logic                               tx_done,    // offered frame sent successfully
	input  wire logic                               tx_abort,   // send ended without success
	output logic                                    tx_pending, // an object is offered
	output logic      [cmo_pkg::IDX_W-1:0]          tx_index,   // offered object number
	output logic                                    tx_remote,  // offered frame is a remote frame
	output logic                                    tx_busy     // a send is in progress
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	////////////////////////////////////////////////////////////////////////////////

	// handshake and bus state, cleared by reset
	typedef struct packed {
		cmo_pkg::cmo_tx_state_t              tx_state;     // idle or sending
		logic [cmo_pkg::IDX_W-1:0]           act_idx;      // object being sent
		logic                                fresh_during; // fresh_data set while sending
		logic [cmo_pkg::DATA_W-1:0]          rd_data;      // registered read word
		logic                                tx_pending;   // offer valid
		logic [cmo_pkg::IDX_W-1:0]           tx_index;     // offered object
		logic                                tx_remote;    // offered frame kind
	} cmo_ctl_t;

	// object storage; deliberately not reset so control elements survive reset
	typedef struct packed {
		logic [cmo_pkg::NUM_OBJ-1:0][cmo_pkg::NUM_ELEM-1:0] el;     // control elements
		logic [cmo_pkg::NUM_OBJ-1:0][cmo_pkg::DATA_W-1:0]   arb_hi; // arbitration upper
		logic [cmo_pkg::NUM_OBJ-1:0][cmo_pkg::DATA_W-1:0]   arb_lo; // arbitration lower
		logic [cmo_pkg::NUM_OBJ-1:0][cmo_pkg::DATA_W-1:0]   cfg;    // config + byte 0
		logic [cmo_pkg::NUM_OBJ-1:0][cmo_pkg::DATA_W-1:0]   d12;    // bytes 1,2
		logic [cmo_pkg::NUM_OBJ-1:0][cmo_pkg::DATA_W-1:0]   d34;    // bytes 3,4
		logic [cmo_pkg::NUM_OBJ-1:0][cmo_pkg::DATA_W-1:0]   d56;    // bytes 5,6
	} cmo_mem_t;

	cmo_ctl_t                            ctl;       // registered control state
	cmo_ctl_t                            next_ctl;  // its next value
	cmo_mem_t                            mem;       // registered object store
	cmo_mem_t                            next_mem;  // its next value
	logic [cmo_pkg::NUM_OBJ-1:0]         elig;      // objects allowed to transmit now
	logic [cmo_pkg::NUM_OBJ-1:0]         rx_hit;    // data frame stored into object
	logic [cmo_pkg::NUM_OBJ-1:0]         rem_hit;   // remote request hits object
	logic [cmo_pkg::NUM_OBJ-1:0]         done_hit;  // object finished sending
	logic [cmo_pkg::NUM_OBJ-1:0]         low_mask;  // objects numbered below tx_index
	logic [cmo_pkg::IDX_W-1:0]           w_idx;     // object selected by addr
	logic [cmo_pkg::OFS_W-1:0]           w_ofs;     // word offset inside the object
	logic                                w_hit;     // addr falls on an existing object

	////////////////////////////////////////////////////////////////////////////////
	// address decode
	////////////////////////////////////////////////////////////////////////////////

	// objects sit on 16-byte boundaries; index 15 has no object and is unmapped
	assign w_idx = addr[cmo_pkg::ADDR_W-1:cmo_pkg::OFS_W];
	assign w_ofs = {addr[cmo_pkg::OFS_W-1:1], 1'b0};
	assign w_hit = (w_idx < cmo_pkg::IDX_W'(cmo_pkg::NUM_OBJ));

	////////////////////////////////////////////////////////////////////////////////
	// next state
	////////////////////////////////////////////////////////////////////////////////

	// one pass: element updates, data stores, read mux, transmit selection
	always_comb
	begin
		logic                          b;        // element being updated
		logic                          hw_set;   // controller sets the element
		logic                          hw_clr;   // controller clears the element
		logic                          cpu_ctl;  // cpu writes this object's control word
		logic [1:0]                    code;     // two-bit code written by the cpu
		logic                          dir;      // object is a transmit object
		logic [cmo_pkg::IDX_W-1:0]     pick;     // lowest eligible object
		logic [cmo_pkg::DATA_W-1:0]    rd_val;   // word addressed by a read
		b       = 1'b0;
		hw_set  = 1'b0;
		hw_clr  = 1'b0;
		cpu_ctl = 1'b0;
		code    = cmo_pkg::CODE_KEEP;
		dir     = 1'b0;
		pick    = cmo_pkg::LAST_OBJ;
		rd_val  = cmo_pkg::ZERO_WORD;
		next_ctl = ctl;
		next_mem = mem;

		// controller events per object; invalid objects see no receive or remote events, but done_hit ignores object_valid
		for (int o = 0; o < cmo_pkg::NUM_OBJ; o++)
		begin
			dir         = mem.cfg[o][cmo_pkg::CFG_DIR_BIT];
			rx_hit[o]   = rx_store && (rx_index == cmo_pkg::IDX_W'(o))
			              && mem.el[o][cmo_pkg::E_VALID];
			rem_hit[o]  = rx_remote && (rx_index == cmo_pkg::IDX_W'(o))
			              && mem.el[o][cmo_pkg::E_VALID] && dir;
			done_hit[o] = tx_done && (ctl.tx_state == cmo_pkg::CMO_SEND)
			              && (ctl.act_idx == cmo_pkg::IDX_W'(o));
			// update_lock holds back data and remote replies alike
			elig[o]     = mem.el[o][cmo_pkg::E_VALID] && mem.el[o][cmo_pkg::E_TX_REQ]
			              && !(dir && mem.el[o][cmo_pkg::E_LOST_LOCK])
			              && (cmo_pkg::IDX_W'(o) != cmo_pkg::LAST_OBJ);
			low_mask[o] = (cmo_pkg::IDX_W'(o) < ctl.tx_index);
		end

		// element update: controller clear, then cpu code, then controller set,
		// so a hardware event landing on a cpu clear is never lost
		for (int o = 0; o < cmo_pkg::NUM_OBJ; o++)
		begin
			cpu_ctl = wr_en && w_hit && (w_idx == cmo_pkg::IDX_W'(o)) && (w_ofs == cmo_pkg::OFS_CTRL);
			for (int e = 0; e < cmo_pkg::NUM_ELEM; e++)
			begin
				b      = mem.el[o][e];
				hw_set = 1'b0;
				hw_clr = 1'b0;
				case (e)
					cmo_pkg::E_IRQ_PEND:
						hw_set = (rx_hit[o] && mem.el[o][cmo_pkg::E_RX_IE])
						      || (done_hit[o] && mem.el[o][cmo_pkg::E_TX_IE]);
					cmo_pkg::E_FRESH:
						hw_set = rx_hit[o];
					cmo_pkg::E_LOST_LOCK:
						hw_set = rx_hit[o] && mem.el[o][cmo_pkg::E_FRESH];
					cmo_pkg::E_TX_REQ, cmo_pkg::E_REMOTE:
					begin
						hw_set = rem_hit[o];
						// a fresh_data set during the send keeps the request
						hw_clr = done_hit[o] && !ctl.fresh_during;
					end
					default:
						hw_set = 1'b0;
				endcase
				b = b & ~hw_clr;
				if (cpu_ctl)
				begin
					code = wr_data[2*e +: 2];
					case (code)
						cmo_pkg::CODE_CLR:  b = 1'b0;
						cmo_pkg::CODE_SET:  b = 1'b1;
						default:            b = b;
					endcase
				end
				b = b | hw_set;
				// last object can hold no transmit state at all
				if ((cmo_pkg::IDX_W'(o) == cmo_pkg::LAST_OBJ) && ((e == cmo_pkg::E_TX_IE)
				    || (e == cmo_pkg::E_TX_REQ) || (e == cmo_pkg::E_REMOTE)))
				begin
					b = 1'b0;
				end
				next_mem.el[o][e] = b;
			end
		end

		// cpu writes to the non-control words; the reserved tail is dropped
		if (wr_en && w_hit)
		begin
			case (w_ofs)
				cmo_pkg::OFS_ARB_HI: next_mem.arb_hi[w_idx] = wr_data;
				cmo_pkg::OFS_ARB_LO: next_mem.arb_lo[w_idx] = wr_data;
				cmo_pkg::OFS_CFG:    next_mem.cfg[w_idx]    = wr_data;
				cmo_pkg::OFS_D12:    next_mem.d12[w_idx]    = wr_data;
				cmo_pkg::OFS_D34:    next_mem.d34[w_idx]    = wr_data;
				cmo_pkg::OFS_D56:    next_mem.d56[w_idx]    = wr_data;
				default:             next_mem.d56[w_idx]    = next_mem.d56[w_idx];
			endcase
		end

		// received payload wins over a same-cycle cpu write; all seven bytes are
		// copied whatever the length, so bytes past the length hold leftovers
		for (int o = 0; o < cmo_pkg::NUM_OBJ; o++)
		begin
			if (rx_hit[o])
			begin
				next_mem.cfg[o][15:8] = rx_data[7:0];
				next_mem.cfg[o][cmo_pkg::CFG_DLC_LSB +: cmo_pkg::DLC_W] = rx_dlc;
				next_mem.d12[o] = rx_data[23:8];
				next_mem.d34[o] = rx_data[39:24];
				next_mem.d56[o] = rx_data[55:40];
			end
		end

		// read mux: each element reads back as 01 or 10
		if (w_hit)
		begin
			case (w_ofs)
				cmo_pkg::OFS_CTRL:
					for (int e = 0; e < cmo_pkg::NUM_ELEM; e++)
					begin
						rd_val[2*e +: 2] = mem.el[w_idx][e] ? cmo_pkg::CODE_SET : cmo_pkg::CODE_CLR;
					end
				cmo_pkg::OFS_ARB_HI: rd_val = mem.arb_hi[w_idx];
				cmo_pkg::OFS_ARB_LO: rd_val = mem.arb_lo[w_idx];
				cmo_pkg::OFS_CFG:    rd_val = mem.cfg[w_idx];
				cmo_pkg::OFS_D12:    rd_val = mem.d12[w_idx];
				cmo_pkg::OFS_D34:    rd_val = mem.d34[w_idx];
				cmo_pkg::OFS_D56:    rd_val = mem.d56[w_idx];
				default:             rd_val = cmo_pkg::ZERO_WORD;
			endcase
		end
		next_ctl.rd_data = rd_en ? rd_val : cmo_pkg::ZERO_WORD;

		// lowest number wins: scan downward so the last hit is the smallest
		for (int o = cmo_pkg::NUM_OBJ - 1; o >= 0; o--)
		begin
			if (elig[o])
			begin
				pick = cmo_pkg::IDX_W'(o);
			end
		end

		// transmit handshake
		case (ctl.tx_state)
			cmo_pkg::CMO_IDLE:
			begin
				if (tx_start && ctl.tx_pending)
				begin
					next_ctl.tx_state     = cmo_pkg::CMO_SEND;
					next_ctl.act_idx      = ctl.tx_index;
					next_ctl.fresh_during = 1'b0;
					next_ctl.tx_pending   = 1'b0;
				end
				else
				begin
					next_ctl.tx_pending = |elig;
					next_ctl.tx_index   = pick;
					// a request on a receive object asks for the data instead
					next_ctl.tx_remote  = !mem.cfg[pick][cmo_pkg::CFG_DIR_BIT];
				end
			end
			cmo_pkg::CMO_SEND:
			begin
				next_ctl.tx_pending = 1'b0;
				// watch for new data arriving from either side during the send
				if ((wr_en && w_hit && (w_idx == ctl.act_idx) && (w_ofs == cmo_pkg::OFS_CTRL)
				     && (wr_data[2*cmo_pkg::E_FRESH +: 2] == cmo_pkg::CODE_SET)) || rx_hit[ctl.act_idx])
				begin
					next_ctl.fresh_during = 1'b1;
				end
				if (tx_done || tx_abort)
				begin
					next_ctl.tx_state = cmo_pkg::CMO_IDLE;
				end
			end
			default:
				next_ctl.tx_state = cmo_pkg::CMO_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	////////////////////////////////////////////////////////////////////////////////

	// control state takes constants under reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ctl <= '0;
		end
		else
		begin
			ctl <= next_ctl;
		end
	end

	// object store has no reset term, so reset cannot disturb it
	always_ff @(posedge clk)
	begin
		mem <= next_mem;
	end

	assign rd_data    = ctl.rd_data;
	assign tx_pending = ctl.tx_pending;
	assign tx_index   = ctl.tx_index;
	assign tx_remote  = ctl.tx_remote;
	assign tx_busy    = (ctl.tx_state == cmo_pkg::CMO_SEND);

	////////////////////////////////////////////////////////////////////////////////
	// checks
	////////////////////////////////////////////////////////////////////////////////

	// the object store is unknown until software writes it; an unknown antecedent
	// leaves a check idle, so these only bite on objects that have been set up

	a_lowest_first: assert property (@(posedge clk) disable iff (reset)
		tx_pending |-> (($past(elig) & low_mask) == '0))
		else $error("a lower numbered object was passed over");

	a_last_never_tx: assert property (@(posedge clk) disable iff (reset)
		tx_pending |-> (tx_index != cmo_pkg::LAST_OBJ))
		else $error("last object offered for transmission");

	a_rx_fresh_irq: assert property (@(posedge clk) disable iff (reset)
		(rx_store && (rx_index < cmo_pkg::LAST_OBJ + 4'h1) && mem.el[rx_index][cmo_pkg::E_VALID]
		 && mem.el[rx_index][cmo_pkg::E_RX_IE])
		|=> (mem.el[$past(rx_index)][cmo_pkg::E_FRESH] && mem.el[$past(rx_index)][cmo_pkg::E_IRQ_PEND]))
		else $error("stored frame did not raise fresh_data and irq_pending");

	a_rx_lost_msg: assert property (@(posedge clk) disable iff (reset)
		(rx_store && (rx_index < cmo_pkg::LAST_OBJ + 4'h1) && mem.el[rx_index][cmo_pkg::E_VALID]
		 && mem.el[rx_index][cmo_pkg::E_FRESH])
		|=> mem.el[$past(rx_index)][cmo_pkg::E_LOST_LOCK])
		else $error("overwrite of unread data not flagged");

	a_invalid_quiet: assert property (@(posedge clk) disable iff (reset)
		(rx_store && !wr_en && !tx_busy && (rx_index < cmo_pkg::LAST_OBJ + 4'h1)
		 && !mem.el[rx_index][cmo_pkg::E_VALID])
		|=> (mem.el[$past(rx_index)] == $past(mem.el[rx_index])))
		else $error("invalid object changed by reception");

	a_remote_request: assert property (@(posedge clk) disable iff (reset)
		(rx_remote && (rx_index < cmo_pkg::LAST_OBJ) && mem.el[rx_index][cmo_pkg::E_VALID]
		 && mem.cfg[rx_index][cmo_pkg::CFG_DIR_BIT])
		|=> (mem.el[$past(rx_index)][cmo_pkg::E_TX_REQ] && mem.el[$past(rx_index)][cmo_pkg::E_REMOTE]))
		else $error("remote request did not set request and remote_pending");

	a_done_clears: assert property (@(posedge clk) disable iff (reset)
		(tx_done && tx_busy && !ctl.fresh_during && !wr_en && !rx_remote)
		|=> !mem.el[$past(ctl.act_idx)][cmo_pkg::E_TX_REQ] && !mem.el[$past(ctl.act_idx)][cmo_pkg::E_REMOTE])
		else $error("successful send left the request standing");

	a_fresh_keeps_req: assert property (@(posedge clk) disable iff (reset)
		(tx_done && tx_busy && ctl.fresh_during && !wr_en && mem.el[ctl.act_idx][cmo_pkg::E_TX_REQ])
		|=> mem.el[$past(ctl.act_idx)][cmo_pkg::E_TX_REQ])
		else $error("request dropped although data was renewed");

	// a send that ends without success must leave the request for a retry
	a_abort_keeps: assert property (@(posedge clk) disable iff (reset)
		(tx_abort && tx_busy && !wr_en && mem.el[ctl.act_idx][cmo_pkg::E_TX_REQ])
		|=> mem.el[$past(ctl.act_idx)][cmo_pkg::E_TX_REQ])
		else $error("failed send dropped the request");

	// follows whichever object the engine last addressed
	a_irq_sticky: assert property (@(posedge clk) disable iff (reset)
		((rx_index < cmo_pkg::LAST_OBJ + 4'h1) && mem.el[rx_index][cmo_pkg::E_IRQ_PEND] && !wr_en)
		|=> mem.el[$past(rx_index)][cmo_pkg::E_IRQ_PEND])
		else $error("irq_pending dropped without a cpu clear");

	a_read_slot: assert property (@(posedge clk) disable iff (reset)
		!$past(rd_en) |-> (rd_data == cmo_pkg::ZERO_WORD))
		else $error("read data outside its slot");

endmodule : cmo_message_objects

`default_nettype wire

// ===== design/cmo_pkg.sv
// constants and state types for the message object control block
package cmo_pkg;

	// object array geometry
	localparam int NUM_OBJ    = 15;          // message objects provided
	localparam int OBJ_STRIDE = 16;          // each object starts on a 16-byte boundary
	localparam int ADDR_W     = 8;           // byte address width covering all objects
	localparam int DATA_W     = 16;          // register word width
	localparam int IDX_W      = 4;           // object index width
	localparam int OFS_W      = 4;           // byte offset width inside one object
	localparam int NUM_ELEM   = 8;           // control elements per object
	localparam int RX_DATA_W  = 64;          // up to eight payload bytes from the engine
	localparam int DLC_W      = 4;           // data length code width

	// word offsets inside one object
	localparam logic [OFS_W-1:0] OFS_CTRL   = 4'h0;  // object_control_word
	localparam logic [OFS_W-1:0] OFS_ARB_HI = 4'h2;  // object_arbitration_upper
	localparam logic [OFS_W-1:0] OFS_ARB_LO = 4'h4;  // object_arbitration_lower
	localparam logic [OFS_W-1:0] OFS_CFG    = 4'h6;  // object_config_and_byte0
	localparam logic [OFS_W-1:0] OFS_D12    = 4'h8;  // object_bytes_1_2
	localparam logic [OFS_W-1:0] OFS_D34    = 4'hA;  // object_bytes_3_4
	localparam logic [OFS_W-1:0] OFS_D56    = 4'hC;  // object_bytes_5_6
	localparam logic [OFS_W-1:0] OFS_RSVD   = 4'hE;  // object_reserved_tail, reads zero

	// element numbers; element k sits at control word bits 2k+1:2k
	localparam int E_IRQ_PEND  = 0;          // irq_pending
	localparam int E_RX_IE     = 1;          // receive_irq_enable
	localparam int E_TX_IE     = 2;          // transmit_irq_enable
	localparam int E_VALID     = 3;          // object_valid
	localparam int E_FRESH     = 4;          // fresh_data
	localparam int E_LOST_LOCK = 5;          // lost_message (rx) / update_lock (tx)
	localparam int E_TX_REQ    = 6;          // transmit_request
	localparam int E_REMOTE    = 7;          // remote_pending

	// two-bit element codes
	localparam logic [1:0] CODE_RSVD = 2'h0; // reserved, no effect
	localparam logic [1:0] CODE_CLR  = 2'h1; // write clears / read means clear
	localparam logic [1:0] CODE_SET  = 2'h2; // write sets / read means set
	localparam logic [1:0] CODE_KEEP = 2'h3; // write leaves unchanged

	// configuration byte layout (low byte of the config word)
	localparam int CFG_DIR_BIT = 3;          // 1 = transmit object, 0 = receive object
	localparam int CFG_DLC_LSB = 4;          // data length code, bits 7:4

	// last object never transmits
	localparam logic [IDX_W-1:0] LAST_OBJ = 4'hE;

	localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

	// transmit handshake states
	typedef enum logic {CMO_IDLE, CMO_SEND} cmo_tx_state_t;

endpackage : cmo_pkg

// ===== test/cmo_engine_model.sv
// protocol engine model: takes the offered object and ends each send after a fixed time
`timescale 1ns/1ps
`default_nettype none
module cmo_engine_model #(parameter int SEND_CYC = 6) (
	input  wire logic clk,        // cpu clock
	input  wire logic reset,      // async, active high
	input  wire logic tx_pending, // an object is offered
	input  wire logic tx_busy,    // a send is in progress
	input  wire logic stall,      // bus busy elsewhere, hold back new sends
	input  wire logic fail,       // end sends by abort instead of success
	output logic      tx_start,   // take the offer
	output logic      tx_done,    // send succeeded
	output logic      tx_abort    // send ended without success
);
	int cnt; // busy cycles of the current send
	////////////////////////////////////////////////////////////////
	// take an offer only while idle; done after SEND_CYC + 1 busy cycles
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			{tx_start, tx_done, tx_abort} <= 3'b000;
			cnt <= 0;
		end
		else
		begin
			tx_start <= tx_pending && !tx_busy && !stall && !tx_start && !tx_done && !tx_abort;
			tx_done  <= tx_busy && cnt == SEND_CYC && !fail;
			tx_abort <= tx_busy && cnt == SEND_CYC && fail;
			// the done cycle still sees busy, so the count steps past and restarts
			cnt      <= (tx_busy && cnt <= SEND_CYC) ? cnt + 1 : 0;
		end
	end
endmodule : cmo_engine_model
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the message object control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0, reset = 1'b1;                   // clock, async reset
	logic [7:0]  addr = 8'h00;                               // byte address
	logic [15:0] wr_data = 16'h0000, rd_data;                // register words
	logic        wr_en = 1'b0, rd_en = 1'b0, stall = 1'b1;   // strobes, engine hold
	logic        fail = 1'b0;                                // engine ends sends by abort
	logic        rx_store = 1'b0, rx_remote = 1'b0;          // engine receive events
	logic [3:0]  rx_index = 4'h0, rx_dlc = 4'h8, tx_index;   // object numbers, length
	logic [63:0] rx_data = 64'h0706_0504_0302_0100;          // fixed payload
	logic        tx_start, tx_done, tx_abort, tx_pending, tx_remote, tx_busy;
	int          n_errors = 0, checks = 0;                   // tallies
	logic [15:0] row_wr [5] = '{16'hFFFE, 16'hFFFB, 16'h0000, 16'hAAFF, 16'h5555}; // writes
	logic [15:0] row_rd [5] = '{16'h5556, 16'h555A, 16'h555A, 16'hAA5A, 16'h5555}; // readback
	always #20 clk = ~clk;
	cmo_message_objects u_cmo_message_objects (.clk(clk), .reset(reset), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_store(rx_store), .rx_remote(rx_remote),
		.rx_index(rx_index), .rx_data(rx_data), .rx_dlc(rx_dlc), .tx_start(tx_start), .tx_done(tx_done),
		.tx_abort(tx_abort), .tx_pending(tx_pending), .tx_index(tx_index), .tx_remote(tx_remote),
		.tx_busy(tx_busy));
	cmo_engine_model #(.SEND_CYC(6)) u_cmo_engine_model (.clk(clk), .reset(reset), .tx_pending(tx_pending),
		.tx_busy(tx_busy), .stall(stall), .fail(fail), .tx_start(tx_start), .tx_done(tx_done),
		.tx_abort(tx_abort));
	////////////////////////////////////////////////////////////////
	// compare and tally
	task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// one-cycle write strobe
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge clk);
		wr_en   <= 1'b0;
	endtask : wr
	// one-cycle read strobe; data stands only in the following cycle
	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		@(negedge clk);
		chk("rd_data", rd_data, exp);
	endtask : rd
	// one engine receive event, data frame or remote request
	task rx(input logic rem, input logic [3:0] idx);
		@(posedge clk);
		rx_store  <= !rem;
		rx_remote <= rem;
		rx_index  <= idx;
		@(posedge clk);
		rx_store  <= 1'b0;
		rx_remote <= 1'b0;
	endtask : rx
	// bounded wait for the busy flag; a hang counts as a mismatch
	task wt(input logic lvl);
		int n;
		n = 0;
		while (tx_busy !== lvl && n < 100)
		begin
			@(negedge clk);
			n++;
		end
		chk("busy wait", {15'h0000, tx_busy}, {15'h0000, lvl});
	endtask : wt
	// let exactly one send start, then hold the engine again
	task send;
		@(posedge clk);
		stall <= 1'b0;
		wt(1'b1);
		@(posedge clk);
		stall <= 1'b1;
	endtask : send
	task results;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////
	// watchdog: the sequence needs well under a thousand cycles
	initial
	begin
		#(40 * 4000);
		n_errors++;
		results();
	end
	initial
	begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 15; i++) wr(8'(i * 16), 16'h5555);
		for (int i = 0; i < 15; i++) wr(8'(i * 16 + 6), 16'h0000);
		// element codes on an invalid object, which must never be offered
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h10, row_wr[i]);
			rd(8'h10, row_rd[i]);
			chk("tx_pending", {15'h0000, tx_pending}, 16'h0000);
		end
		$display("codes done");
		wr(8'h10, 16'hFFEA);
		@(posedge clk);
		reset <= 1'b1;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		rd(8'h10, 16'h556A);
		wr(8'h12, 16'hABCD);
		wr(8'h1E, 16'h1234);
		wr(8'hF2, 16'h4321);
		rd(8'h12, 16'hABCD);
		rd(8'h1E, 16'h0000);
		rd(8'hF2, 16'h0000);
		wr(8'hE0, 16'hAAAA);
		rd(8'hE0, 16'h5A9A);
		wr(8'hE0, 16'h5555);
		$display("map done");
		// reception: flags, payload, overrun, invalid target
		wr(8'h20, 16'hFFBB);
		rx(1'b0, 4'h2);
		rd(8'h20, 16'h569A);
		rd(8'h28, 16'h0201);
		rx(1'b0, 4'h2);
		rd(8'h20, 16'h5A9A);
		rx(1'b0, 4'h1);
		rd(8'h10, 16'h556A);
		$display("receive done");
		// transmit objects 3 and 4 with the engine held back
		wr(8'h36, 16'h0008);
		wr(8'h46, 16'h0008);
		wr(8'h30, 16'hFFAF);
		rx(1'b1, 4'h3);
		rd(8'h30, 16'hA5A5);
		wr(8'h40, 16'hEFBF);
		rd(8'h40, 16'h6595);
		chk("tx_index", {12'h000, tx_index}, 16'h0003);
		wr(8'h30, 16'hFBFF);
		rd(8'h30, 16'hA9A5);
		chk("tx_index", {12'h000, tx_index}, 16'h0004);
		chk("tx_remote", {15'h0000, tx_remote}, 16'h0000);
		send;
		wt(1'b0);
		rd(8'h40, 16'h5595);
		wr(8'h30, 16'hF7FF);
		send;
		wt(1'b0);
		rd(8'h30, 16'h55A6);
		// fresh data written during a send keeps the request
		wr(8'h40, 16'hEFFF);
		send;
		wr(8'h40, 16'hFEFF);
		wt(1'b0);
		rd(8'h40, 16'h6695);
		wr(8'h40, 16'hDF7F);
		// remote frame from a receive object; a store during it keeps the request
		wr(8'h20, 16'hE5FF);
		rd(8'h20, 16'h659A);
		chk("tx_remote", {15'h0000, tx_remote}, 16'h0001);
		send;
		rx(1'b0, 4'h2);
		wt(1'b0);
		rd(8'h20, 16'h669A);
		// a send that ends by abort keeps the request and the offer
		send;
		fail <= 1'b1;
		wt(1'b0);
		rd(8'h20, 16'h669A);
		chk("tx_pending", {15'h0000, tx_pending}, 16'h0001);
		$display("transmit done");
		results();
	end
endmodule : tb_top
`default_nettype wire
